// ==== cc_pin_partner.sv ====
`timescale 1ns/10ps
module cc_pin_partner
   import timer_pkg::*;
#(
   parameter int DLY = 3,
   parameter int EXT_HALF = 170
) (
   // clock
   input wire logic clock_i,
   // levels the bench asks for
   input wire logic [CH_N-1:0][GR_N-1:0] want_i,
   // pins
   output logic [CH_N-1:0][GR_N-1:0] drive_o,
   output logic [EXT_N-1:0] ext_clk_o
);
   // ***************************************************
   // pin drivers
   // ***************************************************
   // edges land off the clock so the design sees truly async inputs
   initial drive_o = '0;
   initial ext_clk_o = '0;
   always @(want_i) begin
      drive_o <= #(DLY) want_i;
   end
   // external count clocks run free, unrelated to clock_i
   always begin
      #(EXT_HALF) ext_clk_o = ~ext_clk_o;
   end
endmodule

// ==== clk_tick.sv ====
`timescale 1ns/10ps
module clk_tick
   import timer_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic arst_n_i,
   // selection
   input wire clk_sel_t sel_i,
   input wire edge_t edge_i,
   input wire logic [EXT_N-1:0] ext_lvl_i,
   // count enable pulse
   output logic tick_o
);
   logic [PRE_W-1:0] pre_q, pre_d;
   logic lvl_q, lvl_d;
   logic tick_q, tick_d;

   always_comb begin
      pre_d = pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
      case (sel_i)
         CLK_DIV1: lvl_d = 1'b0;
         CLK_DIV4: lvl_d = pre_q[PRE_BIT_DIV4];
         CLK_DIV16: lvl_d = pre_q[PRE_BIT_DIV16];
         CLK_DIV64: lvl_d = pre_q[PRE_BIT_DIV64];
         default: lvl_d = ext_lvl_i[sel_i[1:0]];
      endcase
      // the undivided clock ticks every cycle whatever the edge field says
      if (sel_i == CLK_DIV1) begin
         tick_d = 1'b1;
      end else begin
         tick_d = edge_hit(edge_i, lvl_d & ~lvl_q, ~lvl_d & lvl_q);
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pre_q <= '0;
         lvl_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         pre_q <= pre_d;
         lvl_q <= lvl_d;
         tick_q <= tick_d;
      end
   end

   assign tick_o = tick_q;
endmodule

// ==== multi_channel_timer.sv ====
`timescale 1ns/10ps
module multi_channel_timer
   import timer_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic arst_n_i,
   // control
   input wire logic [CH_N-1:0] start_i,
   input wire logic [CH_N-1:0] sync_i,
   input wire ch_cfg_t [CH_N-1:0] ch_cfg_i,
   input wire gr_cfg_t [CH_N-1:0][GR_N-1:0] gr_cfg_i,
   input wire logic [CH_N-1:0] ovf_irq_en_i,
   input wire logic [CH_N-1:0][GR_N-1:0] mc_irq_en_i,
   // software writes and flag clears
   input wire logic [CH_N-1:0] cnt_wr_i,
   input wire logic [CNT_W-1:0] cnt_wdata_i,
   input wire gr_wr_t gr_wr_i,
   input wire logic [CH_N-1:0] ovf_clr_i,
   input wire logic [CH_N-1:0][GR_N-1:0] mc_clr_i,
   // status
   output logic [CH_N-1:0][CNT_W-1:0] cnt_o,
   output logic [CH_N-1:0][GR_N-1:0][CNT_W-1:0] gr_o,
   output logic [CH_N-1:0] ovf_flag_o,
   output logic [CH_N-1:0][GR_N-1:0] mc_flag_o,
   output logic [CH_N-1:0] irq_ovf_o,
   output logic [CH_N-1:0][GR_N-1:0] irq_mc_o,
   // pins
   input wire logic [EXT_N-1:0] ext_clk_i,
   input wire logic [CH_N-1:0][GR_N-1:0] cc_pin_i,
   output logic [CH_N-1:0][GR_N-1:0] cc_pin_o,
   output logic [CH_N-1:0][GR_N-1:0] cc_pin_oe_n_o
);
   // ***************************************************
   // state
   // ***************************************************
   logic [CH_N-1:0][CNT_W-1:0] cnt_q, cnt_d;
   logic [CH_N-1:0][GR_N-1:0][CNT_W-1:0] gr_q, gr_d;
   logic [CH_N-1:0] ovf_q, ovf_d, irq_ovf_q, irq_ovf_d;
   logic [CH_N-1:0][GR_N-1:0] mc_q, mc_d, irq_mc_q, irq_mc_d;
   logic [CH_N-1:0][GR_N-1:0] pin_q, pin_d, oe_n_q, oe_n_d;

   // events
   logic [CH_N-1:0] tick, inc, own_clr, load_v, clr_v, ovf_ev;
   logic [CH_N-1:0][GR_N-1:0] match, cap, pin_rise, pin_fall;
   logic [EXT_N-1:0] ext_lvl;
   logic sync_clr, sync_wr;

   // ***************************************************
   // helpers
   // ***************************************************
   // buffers exist on three channels only
   function automatic logic is_buf_slot(int c, int g, ch_cfg_t cfg);
      is_buf_slot = BUF_CH_MASK[c] &
         (((g == GR_C) & cfg.buf_en_a) | ((g == GR_D) & cfg.buf_en_b));
   endfunction

   // compare or capture both may clear
   function automatic logic clr_hits(clr_src_t s, logic [GR_N-1:0] ev);
      case (s)
         CLR_A: clr_hits = ev[GR_A];
         CLR_B: clr_hits = ev[GR_B];
         CLR_C: clr_hits = ev[GR_C];
         CLR_D: clr_hits = ev[GR_D];
         default: clr_hits = 1'b0;
      endcase
   endfunction

   // ***************************************************
   // pin sync and count clocks
   // ***************************************************
   // capture pins cross into the timer clock
   pin_sync #(.W(CH_N * GR_N)) u_cap_sync (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .pin_i(cc_pin_i),
      .level_o(),
      .rise_o(pin_rise),
      .fall_o(pin_fall)
   );

   pin_sync #(.W(EXT_N)) u_ext_sync (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .pin_i(ext_clk_i),
      .level_o(ext_lvl),
      .rise_o(),
      .fall_o()
   );

   for (genvar c = 0; c < CH_N; c++) begin : g_tick
      clk_tick u_tick (
         .clock_i(clock_i),
         .arst_n_i(arst_n_i),
         .sel_i(ch_cfg_i[c].clk_sel),
         .edge_i(ch_cfg_i[c].clk_edge),
         .ext_lvl_i(ext_lvl),
         .tick_o(tick[c])
      );
   end

   // ***************************************************
   // events
   // ***************************************************
   always_comb begin
      match = '0;
      cap = '0;
      own_clr = '0;
      for (int c = 0; c < CH_N; c++) begin
         inc[c] = start_i[c] & tick[c];
         for (int g = 0; g < GR_N; g++) begin
            // compare uses the value before any clear
            match[c][g] = ~gr_cfg_i[c][g].capture & ~is_buf_slot(c, g, ch_cfg_i[c]) &
               inc[c] & (cnt_q[c] == gr_q[c][g]);
         end
      end
      for (int c = 0; c < CH_N; c++) begin
         for (int g = 0; g < GR_N; g++) begin
            logic ev;
            int other;
            ev = 1'b0;
            other = (c == 0) ? 1 : 0;
            // alternate sources on the first two channels
            if (c < 2 && gr_cfg_i[c][g].cap_src == CAP_TICK) begin
               ev = inc[other];
            end else if (c < 2 && gr_cfg_i[c][g].cap_src == CAP_MATCH) begin
               ev = match[other][GR_A];
            end else begin
               ev = edge_hit(gr_cfg_i[c][g].cap_edge, pin_rise[c][g], pin_fall[c][g]);
            end
            cap[c][g] = gr_cfg_i[c][g].capture & ~is_buf_slot(c, g, ch_cfg_i[c]) & ev;
         end
         own_clr[c] = clr_hits(ch_cfg_i[c].clr_src, match[c] | cap[c]);
      end
      // only channels with the sync bit take part
      sync_clr = |(own_clr & sync_i);
      sync_wr = |(cnt_wr_i & sync_i);
   end

   // ***************************************************
   // counters
   // ***************************************************
   always_comb begin
      for (int c = 0; c < CH_N; c++) begin
         // one write presets every synced counter
         load_v[c] = cnt_wr_i[c] | (sync_i[c] & sync_wr);
         clr_v[c] = own_clr[c] |
            (sync_i[c] & (ch_cfg_i[c].clr_src == CLR_SYNC) & sync_clr);
         ovf_ev[c] = 1'b0;
         cnt_d[c] = cnt_q[c];
         if (load_v[c]) begin
            cnt_d[c] = cnt_wdata_i;
         end else if (clr_v[c]) begin
            cnt_d[c] = CNT_ZERO;
         end else if (inc[c]) begin
            // wrap sets overflow and keeps counting
            cnt_d[c] = cnt_q[c] + CNT_ONE;
            ovf_ev[c] = (cnt_q[c] == CNT_MAX);
         end
      end
   end

   // reset clears every counter to zero; it counts only while its start_i bit is set
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // ***************************************************
   // general registers
   // ***************************************************
   always_comb begin
      gr_d = gr_q;
      for (int c = 0; c < CH_N; c++) begin
         for (int g = 0; g < GR_N; g++) begin
            if (gr_wr_i.en && gr_wr_i.ch == CH_W'(c) && gr_wr_i.idx == IDX_W'(g)) begin
               gr_d[c][g] = gr_wr_i.data;
            end
         end
         // hardware transfers take priority over a software write
         for (int g = 0; g < BUF_OFS; g++) begin
            if (cap[c][g]) begin
               gr_d[c][g] = cnt_q[c];
               // old value shifts into the buffer
               if (is_buf_slot(c, g + BUF_OFS, ch_cfg_i[c])) begin
                  gr_d[c][g + BUF_OFS] = gr_q[c][g];
               end
            end else if (match[c][g] && is_buf_slot(c, g + BUF_OFS, ch_cfg_i[c])) begin
               gr_d[c][g] = gr_q[c][g + BUF_OFS];
            end
         end
         for (int g = BUF_OFS; g < GR_N; g++) begin
            if (cap[c][g]) begin
               gr_d[c][g] = cnt_q[c];
            end
         end
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         gr_q <= {(CH_N * GR_N){GR_RESET}};
      end else begin
         gr_q <= gr_d;
      end
   end

   // ***************************************************
   // flags, interrupts and pins
   // ***************************************************
   always_comb begin
      for (int c = 0; c < CH_N; c++) begin
         // set wins over a clear in the same cycle
         ovf_d[c] = ovf_ev[c] | (ovf_q[c] & ~ovf_clr_i[c]);
         irq_ovf_d[c] = ovf_d[c] & ovf_irq_en_i[c];
         for (int g = 0; g < GR_N; g++) begin
            mc_d[c][g] = match[c][g] | cap[c][g] | (mc_q[c][g] & ~mc_clr_i[c][g]);
            irq_mc_d[c][g] = mc_d[c][g] & mc_irq_en_i[c][g];
            oe_n_d[c][g] = gr_cfg_i[c][g].capture;
            pin_d[c][g] = pin_q[c][g];
            if (!start_i[c]) begin
               // initial level until counting and matching
               pin_d[c][g] = gr_cfg_i[c][g].init_lvl;
            end else if (match[c][g]) begin
               // output action; same level is no change
               case (gr_cfg_i[c][g].act)
                  OUT_LOW: pin_d[c][g] = 1'b0;
                  OUT_HIGH: pin_d[c][g] = 1'b1;
                  OUT_TOGGLE: pin_d[c][g] = ~pin_q[c][g];
                  default: pin_d[c][g] = pin_q[c][g];
               endcase
            end
         end
      end
   end

   // pins float as inputs until configured for output
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ovf_q <= '0;
         irq_ovf_q <= '0;
         mc_q <= '0;
         irq_mc_q <= '0;
         pin_q <= '0;
         oe_n_q <= '1;
      end else begin
         ovf_q <= ovf_d;
         irq_ovf_q <= irq_ovf_d;
         mc_q <= mc_d;
         irq_mc_q <= irq_mc_d;
         pin_q <= pin_d;
         oe_n_q <= oe_n_d;
      end
   end

   assign cnt_o = cnt_q;
   assign gr_o = gr_q;
   assign ovf_flag_o = ovf_q;
   assign mc_flag_o = mc_q;
   assign irq_ovf_o = irq_ovf_q;
   assign irq_mc_o = irq_mc_q;
   assign cc_pin_o = pin_q;
   assign cc_pin_oe_n_o = oe_n_q;

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!arst_n_i);

   a_stopped_hold: assert property (
      !start_i[0] && !load_v[0] && !clr_v[0] |=> cnt_q[0] == $past(cnt_q[0]))
      else $error("stopped counter moved");
   a_wrap_flag: assert property (
      inc[0] && cnt_q[0] == CNT_MAX && !load_v[0] && !clr_v[0]
      |=> ovf_q[0] && cnt_q[0] == CNT_ZERO)
      else $error("wrap did not set overflow");
   a_ovf_irq: assert property (
      ovf_q[0] && ovf_irq_en_i[0] && !ovf_clr_i[0] |=> irq_ovf_q[0])
      else $error("overflow interrupt missing");
   a_period_clear: assert property (
      match[0][GR_A] && ch_cfg_i[0].clr_src == CLR_A && !load_v[0]
      |=> cnt_q[0] == CNT_ZERO && mc_q[0][GR_A])
      else $error("periodic clear failed");
   a_match_irq: assert property (
      (match[1][GR_B] || cap[1][GR_B]) && mc_irq_en_i[1][GR_B] |=> irq_mc_q[1][GR_B])
      else $error("match interrupt missing");
   a_pin_high: assert property (
      start_i[2] && match[2][GR_A] && gr_cfg_i[2][GR_A].act == OUT_HIGH |=> pin_q[2][GR_A])
      else $error("pin not driven high");
   a_pin_toggle: assert property (
      start_i[2] && match[2][GR_B] && gr_cfg_i[2][GR_B].act == OUT_TOGGLE
      |=> pin_q[2][GR_B] != $past(pin_q[2][GR_B]))
      else $error("pin not toggled");
   a_pin_init: assert property (
      !start_i[0] |=> pin_q[0][GR_A] == $past(gr_cfg_i[0][GR_A].init_lvl))
      else $error("initial level not shown");
   a_capture_load: assert property (
      cap[1][GR_A] |=> gr_q[1][GR_A] == $past(cnt_q[1]))
      else $error("capture did not load counter");
   a_sync_preset: assert property (
      cnt_wr_i[0] && sync_i[0] && sync_i[3] |=> cnt_q[3] == $past(cnt_wdata_i))
      else $error("synced preset missed");
   a_sync_clear: assert property (
      own_clr[0] && sync_i[0] && sync_i[1] && ch_cfg_i[1].clr_src == CLR_SYNC
      && !load_v[1] |=> cnt_q[1] == CNT_ZERO)
      else $error("synced clear missed");
   a_buf_compare: assert property (
      match[0][GR_A] && ch_cfg_i[0].buf_en_a |=> gr_q[0][GR_A] == $past(gr_q[0][GR_C]))
      else $error("buffer not transferred");
   a_buf_capture: assert property (
      cap[3][GR_B] && ch_cfg_i[3].buf_en_b
      |=> gr_q[3][GR_D] == $past(gr_q[3][GR_B]) && gr_q[3][GR_B] == $past(cnt_q[3]))
      else $error("capture buffer shift failed");

   c_overflow: cover property (inc[0] && cnt_q[0] == CNT_MAX ##1 ovf_q[0]);
   c_periodic: cover property (match[0][GR_A] && ch_cfg_i[0].clr_src == CLR_A);
   c_sync_clear: cover property (sync_clr ##1 cnt_q[1] == CNT_ZERO);
   c_buf_capture: cover property (cap[3][GR_A] && ch_cfg_i[3].buf_en_a);
endmodule

// ==== pin_sync.sv ====
`timescale 1ns/10ps
module pin_sync
   import timer_pkg::*;
#(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic arst_n_i,
   // raw pins
   input wire logic [W-1:0] pin_i,
   // synchronised level and edges
   output logic [W-1:0] level_o,
   output logic [W-1:0] rise_o,
   output logic [W-1:0] fall_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] prev_q;

   // sync and edge, two flops before any logic
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign rise_o = sync_q & ~prev_q;
   assign fall_o = ~sync_q & prev_q;
   assign level_o = sync_q;
endmodule

// ==== tb_multi_channel_timer.sv ====
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
   $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_multi_channel_timer;
   import timer_pkg::*;
   typedef struct {int w; logic [15:0] e;} note_t;
   // ***************************************************
   // stimulus and wires
   // ***************************************************
   logic clock_i = 0;
   logic arst_n_i = 0;
   logic [CH_N-1:0] start = '0, sync = '0, ovf_en = '0, cnt_wr = '0, ovf_clr = '0;
   ch_cfg_t [CH_N-1:0] ch_cfg = '0;
   gr_cfg_t [CH_N-1:0][GR_N-1:0] gr_cfg = '0;
   logic [CH_N-1:0][GR_N-1:0] mc_en = '0, mc_clr = '0, want = '0, part_pin, pin_w, pin_o, oe_n;
   logic [CNT_W-1:0] cnt_wdata = '0;
   gr_wr_t gr_wr = '0;
   logic [CH_N-1:0][CNT_W-1:0] cnt_o;
   logic [CH_N-1:0][GR_N-1:0][CNT_W-1:0] gr_o;
   logic [CH_N-1:0] ovf_flag, irq_ovf;
   logic [CH_N-1:0][GR_N-1:0] mc_flag, irq_mc;
   logic [EXT_N-1:0] ext_clk;
   logic [31:0] lfsr_q;
   logic [15:0] r, r2;
   note_t q[$];
   note_t n;
   int err_count = 0, cmp_count = 0, cycles = 0;

   always #20 clock_i = ~clock_i;
   // the wire follows whichever side drives it
   assign pin_w = (oe_n & part_pin) | (~oe_n & pin_o);

   multi_channel_timer DUT (.clock_i(clock_i), .arst_n_i(arst_n_i), .start_i(start),
      .sync_i(sync), .ch_cfg_i(ch_cfg), .gr_cfg_i(gr_cfg), .ovf_irq_en_i(ovf_en),
      .mc_irq_en_i(mc_en), .cnt_wr_i(cnt_wr), .cnt_wdata_i(cnt_wdata), .gr_wr_i(gr_wr),
      .ovf_clr_i(ovf_clr), .mc_clr_i(mc_clr), .cnt_o(cnt_o), .gr_o(gr_o),
      .ovf_flag_o(ovf_flag), .mc_flag_o(mc_flag), .irq_ovf_o(irq_ovf), .irq_mc_o(irq_mc),
      .ext_clk_i(ext_clk), .cc_pin_i(pin_w), .cc_pin_o(pin_o), .cc_pin_oe_n_o(oe_n));
   cc_pin_partner pins (.clock_i(clock_i), .want_i(want), .drive_o(part_pin),
      .ext_clk_o(ext_clk));

   // ***************************************************
   // helpers
   // ***************************************************
   function automatic logic [15:0] rnd();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q[15:0];
   endfunction
   function automatic logic [15:0] view(int w);
      case (w)
         0: view = cnt_o[0];
         1: view = {14'h0, ovf_flag[0], irq_ovf[0]};
         2: view = cnt_o[1];
         3: view = {11'h0, mc_flag[1][0], irq_mc[1][0], pin_o[1][0], oe_n[1][0], pin_o[1][1]};
         4: view = gr_o[2][1];
         5: view = {15'h0, mc_flag[2][1]};
         6: view = cnt_o[4];
         7: view = gr_o[0][0];
         9: view = {14'h0, pin_o[2][0], mc_flag[2][0]};
         default: view = gr_o[0][2];
      endcase
   endfunction
   task automatic note(int w, logic [15:0] e);
      q.push_back('{w, e});
   endtask
   task automatic cyc(int k);
      repeat (k) @(negedge clock_i);
   endtask
   task automatic cw(logic [CH_N-1:0] m, logic [15:0] d);
      cnt_wr = m;
      cnt_wdata = d;
      cyc(1);
      cnt_wr = '0;
   endtask
   task automatic grw(int c, int i, logic [15:0] d);
      gr_wr = '{en: 1'b1, ch: c[CH_W-1:0], idx: i[IDX_W-1:0], data: d};
      cyc(1);
      gr_wr.en = 1'b0;
   endtask
   task automatic summarize();
      $display("errors %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ***************************************************
   // watcher and timeout
   // ***************************************************
   // values seen at the edge are those settled since the previous edge
   always @(posedge clock_i) begin
      while (q.size() > 0) begin
         n = q.pop_front();
         `CHK(view(n.w), n.e)
      end
   end
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         summarize();
      end
   end

   // ***************************************************
   // scenarios
   // ***************************************************
   initial begin
      lfsr_q = 32'hf776;
      cyc(20);
      note(0, 16'h0000); // counter zero
      arst_n_i = 1;
      cyc(2);
      ovf_en[0] = 1;
      cw(5'h01, 16'hfffd); // whole word
      cyc(2);
      note(0, 16'hfffd); // stopped holds
      start[0] = 1;
      cyc(3);
      note(0, 16'h0000); // wrap
      note(1, 16'h0003); // flag and request
      cyc(1);
      note(0, 16'h0001); // keeps counting
      ovf_en[0] = 0;
      cyc(1);
      note(1, 16'h0002); // masked request
      ovf_clr[0] = 1;
      cyc(1);
      ovf_clr[0] = 0;
      start[0] = 0;
      note(1, 16'h0000); // flag cleared
      ch_cfg[1].clr_src = CLR_A; // period register
      gr_cfg[1][0].init_lvl = 1;
      gr_cfg[1][0].act = OUT_TOGGLE;
      gr_cfg[1][1].init_lvl = 1;
      gr_cfg[1][1].act = OUT_LOW;
      mc_en[1] = 4'h3;
      grw(1, 0, 16'h0002);
      // let an edge pass so the write strobe is not raised again in the same step
      cyc(1);
      grw(1, 1, 16'h0001);
      note(3, 16'h0005); // initial level
      start[1] = 1;
      cyc(3);
      note(2, 16'h0000); // cleared at match
      note(3, 16'h0018); // flag, irq, pins
      cyc(3);
      note(2, 16'h0000); // period three
      note(3, 16'h001c); // toggle, low kept
      start[1] = 0;
      gr_cfg[2][1].capture = 1;
      gr_cfg[2][1].cap_edge = EDGE_FALL;
      // switched early so the divider phase has settled before counting
      ch_cfg[4].clk_sel = CLK_DIV4;
      r = rnd();
      cw(5'h04, r);
      want[2][1] = 1;
      cyc(6);
      note(4, 16'h0000); // rise ignored
      note(5, 16'h0000); // no flag
      want[2][1] = 0;
      cyc(6);
      note(4, r); // captured
      note(5, 16'h0001); // capture flag
      mc_clr[2][1] = 1;
      cyc(1);
      mc_clr[2][1] = 0;
      note(5, 16'h0000); // flag cleared
      gr_cfg[2][0].act = OUT_HIGH;
      cw(5'h04, 16'hfffe);
      note(9, 16'h0000); // initial low
      start[2] = 1;
      cyc(3);
      note(9, 16'h0003); // high at match
      start[2] = 0;
      sync = 5'h18;
      r = rnd();
      cw(5'h08, r);
      note(6, r); // preset follows
      // any eight edges hold exactly two quarter-rate ticks
      start[4] = 1;
      cyc(8);
      start[4] = 0;
      note(6, r + 16'h0002); // quarter rate
      sync = 5'h03;
      ch_cfg[0].clr_src = CLR_A;
      ch_cfg[1].clr_src = CLR_SYNC;
      ch_cfg[0].buf_en_a = 1; // buffer on
      gr_cfg[0][0].capture = 1;
      gr_cfg[0][0].cap_edge = EDGE_BOTH;
      grw(0, 0, 16'h0055);
      r = rnd();
      cw(5'h01, r);
      want[0][0] = 1;
      note(2, r); // synced preset
      cyc(6);
      note(7, r); // rise captured
      note(8, 16'h0055); // old value moved
      note(0, 16'h0000); // capture clears
      note(2, 16'h0000); // synced clear
      r2 = rnd();
      cw(5'h01, r2);
      want[0][0] = 0;
      cyc(6);
      note(7, r2); // both edges
      note(8, r); // shift again
      cyc(2);
      summarize();
   end
endmodule

// ==== timer_pkg.sv ====
package timer_pkg;
   // ***************************************************
   // sizes
   // ***************************************************
   localparam int CH_N = 5;
   localparam int GR_N = 4;
   localparam int CNT_W = 16;
   localparam int EXT_N = 4;
   localparam int PRE_W = 6;
   localparam int CH_W = 3;
   localparam int IDX_W = 2;

   // ***************************************************
   // values and positions
   // ***************************************************
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] GR_RESET = 16'h0000;
   localparam int GR_A = 0;
   localparam int GR_B = 1;
   localparam int GR_C = 2;
   localparam int GR_D = 3;
   // buffer register index is the general register index plus this
   localparam int BUF_OFS = 2;
   // channels 0, 3 and 4 own buffer registers
   localparam logic [CH_N-1:0] BUF_CH_MASK = 5'h19;
   // prescaler bit that forms the divided clock level
   localparam int PRE_BIT_DIV4 = 1;
   localparam int PRE_BIT_DIV16 = 3;
   localparam int PRE_BIT_DIV64 = 5;

   // ***************************************************
   // encodings
   // ***************************************************
   typedef enum logic [2:0] {
      CLK_DIV1 = 3'h0, CLK_DIV4 = 3'h1, CLK_DIV16 = 3'h2, CLK_DIV64 = 3'h3,
      CLK_EXT0 = 3'h4, CLK_EXT1 = 3'h5, CLK_EXT2 = 3'h6, CLK_EXT3 = 3'h7
   } clk_sel_t;
   typedef enum logic [1:0] {
      EDGE_RISE = 2'h0, EDGE_FALL = 2'h1, EDGE_BOTH = 2'h2, EDGE_BOTH2 = 2'h3
   } edge_t;
   typedef enum logic [2:0] {
      CLR_NONE = 3'h0, CLR_A = 3'h1, CLR_B = 3'h2, CLR_SYNC = 3'h3,
      CLR_NONE2 = 3'h4, CLR_C = 3'h5, CLR_D = 3'h6, CLR_NONE3 = 3'h7
   } clr_src_t;
   typedef enum logic [1:0] {
      OUT_HOLD = 2'h0, OUT_LOW = 2'h1, OUT_HIGH = 2'h2, OUT_TOGGLE = 2'h3
   } out_act_t;
   typedef enum logic [1:0] {
      CAP_PIN = 2'h0, CAP_TICK = 2'h1, CAP_MATCH = 2'h2, CAP_PIN2 = 2'h3
   } cap_src_t;

   typedef struct packed {
      clk_sel_t clk_sel;
      edge_t clk_edge;
      clr_src_t clr_src;
      logic buf_en_a;
      logic buf_en_b;
   } ch_cfg_t;
   typedef struct packed {
      logic capture;
      logic init_lvl;
      out_act_t act;
      edge_t cap_edge;
      cap_src_t cap_src;
   } gr_cfg_t;
   typedef struct packed {
      logic en;
      logic [CH_W-1:0] ch;
      logic [IDX_W-1:0] idx;
      logic [CNT_W-1:0] data;
   } gr_wr_t;

   function automatic logic edge_hit(edge_t e, logic rise, logic fall);
      case (e)
         EDGE_RISE: edge_hit = rise;
         EDGE_FALL: edge_hit = fall;
         default: edge_hit = rise | fall;
      endcase
   endfunction
endpackage
